// *** hw/cbt_bit_timing.sv ***
// bit timing core: segments, sampling, synchronisation, mode
//
// Function
// - each bit is four back to back segments of whole quanta
// - sync segment is exactly one quantum
// - late edge lengthens phase one, delaying the sample point
// - early edge shortens phase two, advancing the next bit
// - phase two from its own field when selected, else from phase one
// - bus is sampled at the phase one to phase two boundary
// - sampling-mode bit set: three samples, majority wins
// - sampling-mode bit clear: one sample decides the bit
// - hard sync once at frame start, resync only inside frames
// - start-of-frame falling edge restarts bit timing
// - edge outside sync adjusts phase by error, capped by jump width
// - jump width from first register bits 7:6, 1 to 4 quanta
// - every length field holds length minus one
// - quantum tick is clock over two times (prescale plus one)
// - bit length is the sum of the four segments
// - mode requested is entered only while the bus is idle, and reported back
`timescale 1ns/1ps
module cbt_bit_timing
    import cbt_pkg::*;
#(
    parameter int PRESCALE_W = 6,
    parameter int SEG_W = 3
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] requested_operating_mode,
    input wire logic bus_idle,
    input wire logic bus_rx,
    input wire logic timing_config_first_wr,
    input wire logic [7:0] timing_config_first_wdata,
    input wire logic timing_config_second_wr,
    input wire logic [15:0] timing_config_second_wdata,
    output logic [2:0] current_operating_mode,
    output logic [7:0] timing_config_first,
    output logic [15:0] timing_config_second,
    output logic sample_point,
    output logic sampled_bit,
    output logic bit_start,
    output logic [1:0] bit_segment
);

    // ========================================================
    // elaboration check
    if (PRESCALE_W != CBT_PRESCALE_W || SEG_W != CBT_SEG_W)
    begin : g_bad_width
        $error("cbt_bit_timing: field widths are fixed by the registers");
    end

    typedef struct packed {
        cbt_seg_t seg;
        logic [CBT_LEN_W-1:0] cnt;
        logic [CBT_LEN_W-1:0] ext;
        logic [CBT_LEN_W-1:0] cut;
        logic resynced;
        logic rx_prev;
        logic [2:0] mode;
        logic [7:0] cfg1;
        logic [15:0] cfg2;
        logic sample;
        logic bit_val;
        logic bit_start;
    } cbt_core_t;

    cbt_core_t q;
    cbt_core_t d;
    cbt_link_if lk ();

    logic run;
    logic fall;
    logic restart_c;
    logic [CBT_LEN_W-1:0] prop_len;
    logic [CBT_LEN_W-1:0] ph1_len;
    logic [CBT_LEN_W-1:0] ph2_len;
    logic [CBT_LEN_W-1:0] sjw_len;
    logic [CBT_ERR_W-1:0] err;
    logic [CBT_ERR_W-1:0] rem;
    logic [CBT_LEN_W-1:0] step;

    // ========================================================
    // helpers
    cbt_prescaler u_prescaler (
        .clk (clk),
        .rst_n (rst_n),
        .lk (lk.pre)
    );

    cbt_sampler u_sampler (
        .clk (clk),
        .rst_n (rst_n),
        .lk (lk.smp)
    );

    assign lk.prescale = q.cfg1[CBT_F1_PRESCALE_LSB +: CBT_PRESCALE_W];
    assign lk.restart = restart_c;
    assign lk.rx = bus_rx;

    // ========================================================
    // decoded lengths
    // fields hold length minus one
    assign prop_len = {1'b0, q.cfg2[CBT_F2_PROP_LSB +: CBT_SEG_W]}
                    + CBT_LEN_W'(1);
    assign ph1_len = {1'b0, q.cfg2[CBT_F2_PH1_LSB +: CBT_SEG_W]}
                   + CBT_LEN_W'(1);
    assign ph2_len = q.cfg2[CBT_F2_PH2SEL_BIT]
                   ? {1'b0, q.cfg2[CBT_F2_PH2_LSB +: CBT_SEG_W]}
                     + CBT_LEN_W'(1)
                   : ph1_len;
    assign sjw_len = {2'b00, q.cfg1[CBT_F1_SJW_LSB +: CBT_SJW_W]}
                   + CBT_LEN_W'(1);

    assign run = (q.mode != CBT_MODE_CONFIG);
    assign fall = q.rx_prev & ~bus_rx;

    always_comb
    begin
        if (q.seg == CBT_SEG_PROP)
            err = {1'b0, q.cnt} + CBT_ERR_W'(1);
        else
            err = {1'b0, prop_len} + {1'b0, q.cnt} + CBT_ERR_W'(1);
        rem = {1'b0, ph2_len} - {1'b0, q.cut} - {1'b0, q.cnt};
        step = (err > {1'b0, sjw_len}) ? sjw_len : err[CBT_LEN_W-1:0];
    end

    // ========================================================
    // next state
    always_comb
    begin
        d = q;
        restart_c = 1'b0;
        d.sample = 1'b0;
        d.bit_start = 1'b0;
        d.rx_prev = bus_rx;

        if (bus_idle)
            d.mode = requested_operating_mode;

        if (timing_config_first_wr && q.mode == CBT_MODE_CONFIG)
            d.cfg1 = timing_config_first_wdata;
        if (timing_config_second_wr && q.mode == CBT_MODE_CONFIG)
            d.cfg2 = timing_config_second_wdata;

        if (!run)
        begin
            d.seg = CBT_SEG_SYNC;
            d.cnt = '0;
            d.ext = '0;
            d.cut = '0;
            d.resynced = 1'b0;
            restart_c = 1'b1;
        end
        // hard sync only while no frame runs
        else if (fall && bus_idle)
        begin
            d.seg = CBT_SEG_SYNC;
            d.cnt = '0;
            d.ext = '0;
            d.cut = '0;
            d.resynced = 1'b1;
            d.bit_start = 1'b1;
            restart_c = 1'b1;
        end
        else
        begin
            if (fall && !q.resynced && q.seg != CBT_SEG_SYNC)
            begin
                d.resynced = 1'b1;
                if (q.seg != CBT_SEG_PH2)
                begin
                    d.ext = step;
                end
                // early edge within jump width starts next bit
                else if (rem <= {1'b0, sjw_len})
                begin
                    d.seg = CBT_SEG_SYNC;
                    d.cnt = '0;
                    d.ext = '0;
                    d.cut = '0;
                    d.bit_start = 1'b1;
                    restart_c = 1'b1;
                end
                else
                begin
                    d.cut = sjw_len;
                end
            end

            if (lk.tq_tick && !restart_c)
            begin
                case (q.seg)
                    CBT_SEG_SYNC:
                    begin
                        d.seg = CBT_SEG_PROP;
                        d.cnt = '0;
                    end
                    CBT_SEG_PROP:
                    begin
                        if (q.cnt + CBT_LEN_W'(1) >= prop_len)
                        begin
                            d.seg = CBT_SEG_PH1;
                            d.cnt = '0;
                        end
                        else
                            d.cnt = q.cnt + CBT_LEN_W'(1);
                    end
                    CBT_SEG_PH1:
                    begin
                        if (q.cnt + CBT_LEN_W'(1) >= ph1_len + d.ext)
                        begin
                            d.seg = CBT_SEG_PH2;
                            d.cnt = '0;
                            d.sample = 1'b1;
                            d.bit_val = q.cfg2[CBT_F2_SAM_BIT]
                                      ? lk.rx_major : bus_rx;
                        end
                        else
                            d.cnt = q.cnt + CBT_LEN_W'(1);
                    end
                    CBT_SEG_PH2:
                    begin
                        // bit ends after the fourth segment
                        if (q.cnt + d.cut + CBT_LEN_W'(1) >= ph2_len)
                        begin
                            d.seg = CBT_SEG_SYNC;
                            d.cnt = '0;
                            d.ext = '0;
                            d.cut = '0;
                            d.resynced = 1'b0;
                            d.bit_start = 1'b1;
                        end
                        else
                            d.cnt = q.cnt + CBT_LEN_W'(1);
                    end
                    default:
                    begin
                        d.seg = CBT_SEG_SYNC;
                        d.cnt = '0;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.seg <= CBT_SEG_SYNC;
            q.rx_prev <= 1'b1;
            q.mode <= CBT_MODE_RST;
            q.cfg1 <= CBT_CFG1_RST;
            q.cfg2 <= CBT_CFG2_RST;
            q.bit_val <= 1'b1;
        end
        else
            q <= d;
    end

    // ========================================================
    // outputs
    assign current_operating_mode = q.mode;
    assign timing_config_first = q.cfg1;
    assign timing_config_second = q.cfg2;
    assign sample_point = q.sample;
    assign sampled_bit = q.bit_val;
    assign bit_start = q.bit_start;
    assign bit_segment = q.seg;

    // ========================================================
    // checks
    property p_hold_cfg;
        @(posedge clk) disable iff (!rst_n)
        q.mode == CBT_MODE_CONFIG |=> q.seg == CBT_SEG_SYNC && q.cnt == '0;
    endproperty
    a_hold_cfg: assert property (p_hold_cfg)
        else $error("segments run in configuration mode");

    property p_sync_one;
        @(posedge clk) disable iff (!rst_n)
        q.seg == CBT_SEG_SYNC && lk.tq_tick && run && !restart_c
            |=> q.seg == CBT_SEG_PROP;
    endproperty
    a_sync_one: assert property (p_sync_one)
        else $error("sync segment not one quantum");

    property p_sample_edge;
        @(posedge clk) disable iff (!rst_n)
        q.sample |-> $past(q.seg) == CBT_SEG_PH1 && q.seg == CBT_SEG_PH2;
    endproperty
    a_sample_edge: assert property (p_sample_edge)
        else $error("sample not at phase boundary");

    property p_triple;
        @(posedge clk) disable iff (!rst_n)
        q.sample && q.cfg2[CBT_F2_SAM_BIT] |-> q.bit_val == $past(lk.rx_major);
    endproperty
    a_triple: assert property (p_triple)
        else $error("triple sample not majority");

    property p_single;
        @(posedge clk) disable iff (!rst_n)
        q.sample && !q.cfg2[CBT_F2_SAM_BIT] |-> q.bit_val == $past(bus_rx);
    endproperty
    a_single: assert property (p_single)
        else $error("single sample wrong");

    property p_hard_sync;
        @(posedge clk) disable iff (!rst_n)
        run && fall && bus_idle
            |=> q.seg == CBT_SEG_SYNC && q.cnt == '0 && q.bit_start;
    endproperty
    a_hard_sync: assert property (p_hard_sync)
        else $error("hard sync did not restart bit");

    property p_cap;
        @(posedge clk) disable iff (!rst_n)
        q.ext != '0 || q.cut != '0 |-> q.ext <= sjw_len && q.cut <= sjw_len;
    endproperty
    a_cap: assert property (p_cap)
        else $error("phase change beyond jump width");

    property p_mode;
        @(posedge clk) disable iff (!rst_n)
        bus_idle |=> q.mode == $past(requested_operating_mode);
    endproperty
    a_mode: assert property (p_mode)
        else $error("requested mode not reported");

    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        q.mode != CBT_MODE_CONFIG |=> $stable(q.cfg1) && $stable(q.cfg2);
    endproperty
    a_lock: assert property (p_lock)
        else $error("timing changed outside configuration");

endmodule : cbt_bit_timing

// *** hw/cbt_pkg.sv ***
// constants and types shared by the bit timing block
package cbt_pkg;

    // ========================================================
    // field widths
    localparam int CBT_PRESCALE_W = 6;
    localparam int CBT_SEG_W = 3;
    localparam int CBT_SJW_W = 2;
    localparam int CBT_LEN_W = 4;
    localparam int CBT_ERR_W = 5;

    // ========================================================
    // operating mode codes
    localparam logic [2:0] CBT_MODE_NORMAL = 3'h0;
    localparam logic [2:0] CBT_MODE_CONFIG = 3'h4;
    localparam logic [2:0] CBT_MODE_RST = 3'h4;

    // ========================================================
    // first timing register layout
    localparam int CBT_F1_PRESCALE_LSB = 0;
    localparam int CBT_F1_SJW_LSB = 6;
    localparam logic [7:0] CBT_CFG1_RST = 8'h00;

    // ========================================================
    // second timing register layout
    localparam int CBT_F2_PROP_LSB = 0;
    localparam int CBT_F2_PH1_LSB = 3;
    localparam int CBT_F2_SAM_BIT = 6;
    localparam int CBT_F2_PH2SEL_BIT = 7;
    localparam int CBT_F2_PH2_LSB = 8;
    localparam logic [15:0] CBT_CFG2_RST = 16'h0000;

    // ========================================================
    // bit segments, gray coded along the bit
    typedef enum logic [1:0] {
        CBT_SEG_SYNC = 2'h0,
        CBT_SEG_PROP = 2'h1,
        CBT_SEG_PH1 = 2'h3,
        CBT_SEG_PH2 = 2'h2
    } cbt_seg_t;

endpackage : cbt_pkg

// *** hw/cbt_link_if.sv ***
// internal links between the bit timing core and its helpers
`timescale 1ns/1ps
interface cbt_link_if;
    import cbt_pkg::*;
    logic [CBT_PRESCALE_W-1:0] prescale;
    logic restart;
    logic tq_tick;
    logic rx;
    logic rx_major;

    modport pre (input prescale, input restart, output tq_tick);
    modport smp (input rx, input tq_tick, output rx_major);
    modport core (output prescale, output restart, input tq_tick,
                  output rx, input rx_major);
endinterface : cbt_link_if

// *** hw/cbt_prescaler.sv ***
// time quantum tick generator
`timescale 1ns/1ps
module cbt_prescaler
    import cbt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    cbt_link_if.pre lk
);

    typedef struct packed {
        logic [CBT_PRESCALE_W:0] cnt;
        logic [CBT_PRESCALE_W+1:0] gap;
    } cbt_pre_t;

    cbt_pre_t q;
    cbt_pre_t d;
    logic [CBT_PRESCALE_W:0] limit;

    // ========================================================
    // divider
    // two clocks per prescale step
    assign limit = {lk.prescale, 1'b1};
    assign lk.tq_tick = (q.cnt == limit);

    always_comb
    begin
        d = q;
        if (lk.restart || lk.tq_tick)
        begin
            d.cnt = '0;
            d.gap = (CBT_PRESCALE_W+2)'(1);
        end
        else
        begin
            d.cnt = q.cnt + (CBT_PRESCALE_W+1)'(1);
            d.gap = q.gap + (CBT_PRESCALE_W+2)'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    // ========================================================
    // checks
    property p_tq_period;
        @(posedge clk) disable iff (!rst_n)
        lk.tq_tick |-> q.gap == ({1'b0, limit} + (CBT_PRESCALE_W+2)'(1));
    endproperty
    a_tq_period: assert property (p_tq_period)
        else $error("quantum tick period wrong");

endmodule : cbt_prescaler

// *** hw/cbt_sampler.sv ***
// bus sample history and three-sample majority
`timescale 1ns/1ps
module cbt_sampler
    import cbt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    cbt_link_if.smp lk
);

    typedef struct packed {
        logic [1:0] hist;
    } cbt_smp_t;

    cbt_smp_t q;
    cbt_smp_t d;

    // ========================================================
    // history and vote
    // majority of three
    assign lk.rx_major = (q.hist[1] & q.hist[0]) | (q.hist[1] & lk.rx)
                       | (q.hist[0] & lk.rx);

    always_comb
    begin
        d = q;
        if (lk.tq_tick)
            d.hist = {q.hist[0], lk.rx};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '1;
        else
            q <= d;
    end

endmodule : cbt_sampler

// *** test/cbt_can_node.sv ***
// bus node model: one dominant pulse per trigger, recessive otherwise
`timescale 1ns/1ps
module cbt_can_node (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic [11:0] lead,
    input wire logic [11:0] width,
    output logic bus_rx
);
    logic [11:0] t_q;

    // ========================================================
    // pulse timer, parked at all ones between pulses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            t_q <= 12'hFFF;
        else if (fire)
            t_q <= 12'h000;
        else if (t_q != 12'hFFF)
            t_q <= t_q + 12'h001;
    end

    // released bus returns to recessive through the termination
    assign bus_rx = !(t_q >= lead && t_q < lead + width);
endmodule : cbt_can_node

// *** test/can_bit_timing_tb_top.sv ***
// self-checking bench for the bit timing core
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
$display("Error at %0t: got %h expected %h", $time, g, e); \
n_fail++; end end
module can_bit_timing_tb_top
    import cbt_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] req = CBT_MODE_CONFIG;
    logic idle = 1'b1;
    logic wr1 = 1'b0;
    logic wr2 = 1'b0;
    logic [7:0] wd1 = 8'h00;
    logic [15:0] wd2 = 16'h0000;
    logic fire = 1'b0;
    logic [11:0] lead = 12'h000;
    logic [11:0] width = 12'h000;
    logic rx;
    logic [2:0] mode;
    logic [7:0] cfg1;
    logic [15:0] cfg2;
    logic sp;
    logic sbit;
    logic bst;
    logic [1:0] seg;
    int n_fail = 0;
    int n_compared = 0;

    always #2 clk = ~clk;

    cbt_bit_timing i_cbt_bit_timing (
        .clk(clk), .rst_n(rst_n), .requested_operating_mode(req),
        .bus_idle(idle), .bus_rx(rx), .timing_config_first_wr(wr1),
        .timing_config_first_wdata(wd1), .timing_config_second_wr(wr2),
        .timing_config_second_wdata(wd2), .current_operating_mode(mode),
        .timing_config_first(cfg1), .timing_config_second(cfg2),
        .sample_point(sp), .sampled_bit(sbit), .bit_start(bst),
        .bit_segment(seg)
    );

    cbt_can_node i_cbt_can_node (
        .clk(clk), .rst_n(rst_n), .fire(fire), .lead(lead),
        .width(width), .bus_rx(rx)
    );

    // ========================================================
    // helpers
    task automatic end_sim;
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // software limits on the timing fields
    function automatic bit cfg_ok(logic [7:0] a, logic [15:0] b);
        int p;
        int h1;
        int h2;
        p = b[2:0] + 1;
        h1 = b[5:3] + 1;
        h2 = b[7] ? b[10:8] + 1 : h1;
        return (1 + p + h1 + h2 inside {[8:25]}) && (h2 > a[7:6] + 1)
            && (p + h1 >= h2);
    endfunction : cfg_ok

    // which 0 waits for a sample pulse, 1 for a bit start
    task automatic upto(input int which, output int at);
        at = 0;
        for (int i = 2; i < 4000; i++)
        begin
            @(posedge clk);
            #1;
            if ((which == 0 ? sp : bst) === 1'b1)
            begin
                at = i;
                return;
            end
        end
        `CHK(1'b0, 1'b1)
        end_sim();
    endtask : upto

    task automatic set_mode(input logic [2:0] m);
        @(negedge clk);
        req <= m;
        idle <= 1'b1;
        for (int i = 0; i < 8 && mode !== m; i++)
            @(negedge clk);
        `CHK(mode, m)
        if (mode !== m)
            end_sim();
    endtask : set_mode

    task automatic wr_cfg(input logic [7:0] d1, input logic [15:0] d2);
        @(negedge clk);
        wr1 <= 1'b1;
        wr2 <= 1'b1;
        wd1 <= d1;
        wd2 <= d2;
        @(negedge clk);
        wr1 <= 1'b0;
        wr2 <= 1'b0;
        @(negedge clk);
    endtask : wr_cfg

    task automatic set_cfg(input logic [7:0] d1, input logic [15:0] d2);
        set_mode(CBT_MODE_CONFIG);
        wr_cfg(d1, d2);
        `CHK(cfg1, d1)
        `CHK(cfg2, d2)
        set_mode(CBT_MODE_NORMAL);
    endtask : set_cfg

    task automatic pulse(input int l, input int w);
        int d;
        upto(1, d);
        @(negedge clk);
        lead <= 12'(l);
        width <= 12'(w);
        fire <= 1'b1;
        @(negedge clk);
        fire <= 1'b0;
    endtask : pulse

    // one free running bit: segment lengths and sample position
    task automatic meas(input logic [7:0] c1, input logic [15:0] c2);
        int n[4];
        int spi;
        int i;
        int q;
        int l1;
        int l2;
        q = 2 * (c1[5:0] + 1);
        l1 = c2[5:3] + 1;
        l2 = c2[7] ? c2[10:8] + 1 : l1;
        n = '{0, 0, 0, 0};
        spi = -1;
        upto(1, i);
        for (i = 0; i < 4000 && !(i > 0 && bst === 1'b1); i++)
        begin
            n[seg] = n[seg] + 1;
            if (sp === 1'b1)
                spi = i;
            @(posedge clk);
            #1;
        end
        `CHK(n[CBT_SEG_SYNC], q)
        `CHK(n[CBT_SEG_PROP], (c2[2:0] + 1) * q)
        `CHK(n[CBT_SEG_PH1], l1 * q)
        `CHK(n[CBT_SEG_PH2], l2 * q)
        `CHK(i, (2 + c2[2:0] + l1 + l2) * q)
        `CHK(spi, (2 + c2[2:0] + l1) * q)
    endtask : meas

    // ========================================================
    // main sequence
    initial
    begin
        logic [7:0] d1;
        logic [15:0] d2;
        int at;
        int l;
        void'($urandom(32'h246d));
        repeat (4) @(negedge clk);
        `CHK(mode, CBT_MODE_RST)
        `CHK(cfg1, CBT_CFG1_RST)
        `CHK(bst, 1'b0)
        rst_n <= 1'b1;
        for (int c = 0; c < 8; c++)
            set_mode(c[2:0]);
        idle <= 1'b0;
        req <= CBT_MODE_CONFIG;
        repeat (4) @(negedge clk);
        `CHK(mode, 3'h7)
        set_mode(CBT_MODE_CONFIG);
        repeat (20) @(negedge clk);
        `CHK(seg, CBT_SEG_SYNC)
        for (int r = 0; r < 14; r++)
        begin
            d1 = 8'h00;
            d2 = 16'h0000;
            if (r == 0)
                d2 = 16'h0010;
            else if (r == 1)
                {d1, d2} = {8'hFF, 16'hFFBF};
            while (!cfg_ok(d1, d2))
            begin
                d1 = 8'($urandom) & 8'hC3;
                d2 = 16'($urandom);
            end
            set_cfg(d1, d2);
            wr_cfg(~d1, ~d2);
            `CHK(cfg1, d1)
            `CHK(cfg2, d2)
            meas(d1, d2);
        end
        for (int s = 0; s < 2; s++)
        begin
            set_cfg(8'h41, 16'h04AB | (16'(s) << 6));
            idle <= 1'b0;
            pulse(0, 42);
            upto(0, at);
            `CHK(sbit, logic'(s == 0))
        end
        for (int s = 0; s < 4; s++)
        begin
            set_cfg({s[1:0], 6'h01}, 16'h04AB);
            idle <= 1'b0;
            pulse(24, 8);
            upto(0, at);
            `CHK(at, 48 + 4 * s)
            if (s < 3)
            begin
                pulse(43, 4);
                upto(1, at);
                `CHK(at, 60 - 4 * s)
            end
            pulse(60, 4);
            upto(1, at);
            `CHK(at, 62)
        end
        // let the last dominant pulse end before hard sync tests
        repeat (8) @(negedge clk);
        idle <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            l = $urandom_range(60);
            @(negedge clk);
            lead <= 12'(l);
            width <= 12'h004;
            fire <= 1'b1;
            @(negedge clk);
            fire <= 1'b0;
            repeat (l + 1) @(posedge clk);
            #1;
            `CHK(bst, 1'b1)
            repeat (44) @(posedge clk);
            #1;
            `CHK(sp, 1'b1)
            repeat (90) @(negedge clk);
        end
        rst_n <= 1'b0;
        @(negedge clk);
        `CHK(mode, CBT_MODE_RST)
        `CHK(cfg2, CBT_CFG2_RST)
        `CHK(seg, CBT_SEG_SYNC)
        end_sim();
    end
endmodule : can_bit_timing_tb_top
